// ==== coc_charge_option.sv ====
// charge option register with serial bus slave, watchdog and control outputs
`timescale 1ns/1ps
module coc_charge_option import coc_pkg::*; #(
  parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       battery_present_pin_n_i,
  input  wire logic       battery_only_i,
  input  wire logic       otg_mode_i,
  input  wire logic       adapter_detect_i,
  input  wire logic       pass_through_mode_i,
  input  wire logic       settings_valid_i,
  input  wire logic       bat_mon_en_i,
  input  wire logic       sys_pwr_mon_en_i,
  input  wire logic       adc_en_i,
  input  wire logic       throttle_en_i,
  input  wire logic       comparator_en_i,
  output logic            internal_regulator_on_o,
  output logic            battery_current_monitor_on_o,
  output logic            system_power_monitor_on_o,
  output logic            adc_sampling_on_o,
  output logic            throttle_output_on_o,
  output logic            comparator_on_o,
  output logic            adapter_good_out_o,
  output logic            pulse_skip_floor_o,
  output logic            switching_rate_800k_o,
  output logic            passthrough_ripple_reduce_o,
  output logic            hiccup_on_o,
  output logic            gauge_calibrate_discharge_o,
  output logic            input_sense_gain_40x_o,
  output logic            battery_sense_gain_16x_o,
  output logic            linear_precharge_on_o,
  output logic            input_limit_regulation_o,
  output logic            charge_run_o,
  output logic            wdog_expired_o,
  output logic            charge_current_zero_o,
  output logic            ext_wr_o,
  output logic [7:0]      ext_addr_o,
  output logic [7:0]      ext_data_o
);

  typedef struct packed {
    coc_bus_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic        bat_q;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        rx_data;
    logic        ack_on;
    logic        mnack;
    logic        sda_oe;
    logic        sda_out;
    logic [15:0] cfg;
    logic        expired;
    logic        cur_zero;
    logic        kick;
    logic        ext_wr;
    logic [7:0]  ext_addr;
    logic [7:0]  ext_data;
    logic        regulator_on;
    logic        bat_mon_on;
    logic        sys_mon_on;
    logic        adc_on;
    logic        throttle_on;
    logic        comparator_on;
    logic        adapter_good;
    logic        skip_floor;
    logic        rate_800k;
    logic        ripple_reduce;
    logic        hiccup_on;
    logic        gauge_cal;
    logic        in_gain_40x;
    logic        bat_gain_16x;
    logic        linear_prechg;
    logic        limit_reg;
    logic        charge_run;
  } coc_state_t;

  localparam coc_state_t ST_RESET = '{
    st:      ST_IDLE,
    scl_q:   1'b1,
    sda_q:   1'b1,
    bat_q:   1'b1,
    cfg:     CFG_RESET,
    default: '0
  };

  coc_state_t q;
  coc_state_t n;
  logic [2:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       bat_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       bat_fall;
  logic       wd_expire;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;

  // pins into the clock domain
  coc_sync #(
    .W (3)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .d_i       ({battery_present_pin_n_i, sda_i, scl_i}),
    .q_o       (pin_s)
  );

  coc_wdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wdog (
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .period_sel_i (q.cfg[BIT_WD_SEL_LO +: 2]),
    .kick_i       (q.kick),
    .expire_o     (wd_expire)
  );

  assign scl_s     = pin_s[0];
  assign sda_s     = pin_s[1];
  assign bat_s     = pin_s[2];
  assign scl_rise  = scl_s & ~q.scl_q;
  assign scl_fall  = ~scl_s & q.scl_q;
  assign bus_start = scl_s & q.scl_q & q.sda_q & ~sda_s;
  assign bus_stop  = scl_s & q.scl_q & ~q.sda_q & sda_s;
  assign bat_fall  = ~bat_s & q.bat_q;
  assign rx_byte   = {q.shreg[6:0], sda_s};

  // read data for the current pointer
  always_comb begin
    if (q.ptr == REG_OPT_LO) begin
      rd_byte = q.cfg[7:0];
    end else if (q.ptr == REG_OPT_HI) begin
      rd_byte = q.cfg[15:8];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    logic       load_tx;
    logic       wr_en;
    logic       lp_gate;
    load_tx = 1'b0;
    wr_en   = 1'b0;
    lp_gate = 1'b0;
    n = q;
    n.scl_q    = scl_s;
    n.sda_q    = sda_s;
    n.bat_q    = bat_s;
    n.kick     = 1'b0;
    n.ext_wr   = 1'b0;
    n.cur_zero = 1'b0;

    // bus slave
    if (bus_stop) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
      n.ack_on = 1'b0;
    end else if (bus_start) begin
      n.st     = ST_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      n.ack_on = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            n.shreg  = rx_byte;
            n.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == 4'h7) begin
              n.bitcnt = 4'h0;
              if (q.st == ST_ADDR) begin
                if (q.shreg[6:0] == I2C_DEV_ADDR) begin
                  n.rw      = sda_s;
                  n.rx_data = 1'b0;
                  n.st      = ST_ACK;
                end else begin
                  n.st = ST_IDLE;
                end
              end else begin
                n.st = ST_ACK;
                if (!q.rx_data) begin
                  n.ptr     = rx_byte;
                  n.rx_data = 1'b1;
                end else begin
                  wr_en = 1'b1;
                  n.ptr = q.ptr + 8'h01;
                end
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!q.ack_on) begin
              n.ack_on = 1'b1;
              n.sda_oe = 1'b1;
            end else begin
              n.ack_on = 1'b0;
              n.sda_oe = 1'b0;
              if (q.rw) begin
                load_tx = 1'b1;
              end else begin
                n.st = ST_RX;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            n.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (q.bitcnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.bitcnt = 4'h0;
              n.st     = ST_MACK;
            end else begin
              n.shreg  = {q.shreg[6:0], 1'b0};
              n.sda_oe = ~q.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            n.mnack = sda_s;
          end
          if (scl_fall) begin
            if (q.mnack) begin
              n.st = ST_IDLE;
            end else begin
              load_tx = 1'b1;
            end
          end
        end
      endcase
    end

    if (load_tx) begin
      n.shreg  = rd_byte;
      n.sda_oe = ~rd_byte[7];
      n.bitcnt = 4'h0;
      n.ptr    = q.ptr + 8'h01;
      n.st     = ST_TX;
    end

    // battery pin falling with auto-off armed drops the limit enable
    if (q.cfg[BIT_LIMIT_AUTO_OFF] && bat_fall) begin
      n.cfg[BIT_INPUT_LIMIT_ON] = 1'b0;
    end

    // register writes; a same-cycle host write of the low byte overrides the auto clear
    if (wr_en) begin
      if (q.ptr == REG_OPT_LO) begin
        n.cfg[7:0] = rx_byte;
      end else if (q.ptr == REG_OPT_HI) begin
        n.cfg[15:8] = rx_byte;
        n.kick      = 1'b1;
      end else if (q.ptr >= REG_CUR_LO && q.ptr <= REG_VOLT_HI) begin
        n.ext_wr   = 1'b1;
        n.ext_addr = q.ptr;
        n.ext_data = rx_byte;
        n.kick     = 1'b1;
      end
    end

    if (!bat_s) begin
      n.cfg[BIT_GAUGE_CAL] = 1'b0;
    end

    // watchdog timeout flag, expiry wins over a same-cycle clear
    if (n.kick) begin
      n.expired = 1'b0;
    end
    if (wd_expire) begin
      n.expired  = 1'b1;
      n.cur_zero = 1'b1;
    end

    // control outputs
    lp_gate = n.cfg[BIT_LOW_POWER] & battery_only_i;
    n.regulator_on  = ~lp_gate;
    n.bat_mon_on    = bat_mon_en_i & ~lp_gate;
    n.sys_mon_on    = sys_pwr_mon_en_i & ~lp_gate;
    n.adc_on        = adc_en_i & ~lp_gate;
    n.throttle_on   = throttle_en_i;
    n.comparator_on = comparator_en_i;
    n.adapter_good  = adapter_detect_i
                    | (n.cfg[BIT_SRC_FLAGS_GOOD] & otg_mode_i);
    n.skip_floor    = n.cfg[BIT_AUDIO_AVOID];
    n.rate_800k     = n.cfg[BIT_RATE_SEL];
    n.ripple_reduce = n.cfg[BIT_RIPPLE_REDUCE] & pass_through_mode_i;
    n.hiccup_on     = ~n.cfg[BIT_SHORT_RETRY];
    n.gauge_cal     = n.cfg[BIT_GAUGE_CAL];
    n.in_gain_40x   = n.cfg[BIT_IN_GAIN];
    n.bat_gain_16x  = n.cfg[BIT_BAT_GAIN];
    n.linear_prechg = n.cfg[BIT_LINEAR_PRECHG];
    n.limit_reg     = n.cfg[BIT_INPUT_LIMIT_ON];
    n.charge_run    = ~n.cfg[BIT_CHARGE_BLOCK] & settings_valid_i
                    & ~n.expired;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= ST_RESET;
    end else begin
      q <= n;
    end
  end

  assign sda_o                        = q.sda_out;
  assign sda_oe_o                     = q.sda_oe;
  assign internal_regulator_on_o      = q.regulator_on;
  assign battery_current_monitor_on_o = q.bat_mon_on;
  assign system_power_monitor_on_o    = q.sys_mon_on;
  assign adc_sampling_on_o            = q.adc_on;
  assign throttle_output_on_o         = q.throttle_on;
  assign comparator_on_o              = q.comparator_on;
  assign adapter_good_out_o           = q.adapter_good;
  assign pulse_skip_floor_o           = q.skip_floor;
  assign switching_rate_800k_o        = q.rate_800k;
  assign passthrough_ripple_reduce_o  = q.ripple_reduce;
  assign hiccup_on_o                  = q.hiccup_on;
  assign gauge_calibrate_discharge_o  = q.gauge_cal;
  assign input_sense_gain_40x_o       = q.in_gain_40x;
  assign battery_sense_gain_16x_o     = q.bat_gain_16x;
  assign linear_precharge_on_o        = q.linear_prechg;
  assign input_limit_regulation_o     = q.limit_reg;
  assign charge_run_o                 = q.charge_run;
  assign wdog_expired_o               = q.expired;
  assign charge_current_zero_o        = q.cur_zero;
  assign ext_wr_o                     = q.ext_wr;
  assign ext_addr_o                   = q.ext_addr;
  assign ext_data_o                   = q.ext_data;

endmodule

// ==== coc_charge_option_chk.sv ====
// assertion checker for the charge option block
`timescale 1ns/1ps
module coc_charge_option_chk (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       battery_present_pin_n_i,
  input wire logic       otg_mode_i,
  input wire logic       adapter_detect_i,
  input wire logic       pass_through_mode_i,
  input wire logic       settings_valid_i,
  input wire logic       bat_mon_en_i,
  input wire logic       internal_regulator_on_o,
  input wire logic       battery_current_monitor_on_o,
  input wire logic       adapter_good_out_o,
  input wire logic       passthrough_ripple_reduce_o,
  input wire logic       gauge_calibrate_discharge_o,
  input wire logic       charge_run_o,
  input wire logic       wdog_expired_o,
  input wire logic       charge_current_zero_o,
  input wire logic       ext_wr_o,
  input wire logic [7:0] ext_addr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  chk_low_power_off: assert property (
    !internal_regulator_on_o |-> !battery_current_monitor_on_o) else $error("monitor on");
  chk_monitor_follow: assert property (
    !$past(reset_i) && battery_current_monitor_on_o |-> $past(bat_mon_en_i))
    else $error("monitor without enable");
  chk_adapter_good: assert property (
    !$past(reset_i) && adapter_good_out_o && !$past(adapter_detect_i) |-> $past(otg_mode_i))
    else $error("adapter good without cause");
  chk_ripple_mode: assert property (
    !$past(reset_i) && passthrough_ripple_reduce_o |-> $past(pass_through_mode_i))
    else $error("ripple reduce outside pass-through");
  chk_run_valid: assert property (
    !$past(reset_i) && charge_run_o |-> $past(settings_valid_i)) else $error("run invalid");
  chk_zero_flag: assert property (
    $rose(charge_current_zero_o) |-> ##[0:1] wdog_expired_o) else $error("zero without flag");
  chk_zero_once: assert property (
    charge_current_zero_o |=> !charge_current_zero_o [*8]) else $error("zero repeated");
  chk_expired_halt: assert property (
    wdog_expired_o && $past(wdog_expired_o) |-> !charge_run_o) else $error("run after expiry");
  chk_ext_range: assert property (
    ext_wr_o |-> ext_addr_o inside {[8'h02:8'h05]}) else $error("setting write out of range");
  chk_calib_clear: assert property (
    (!battery_present_pin_n_i) [*8] |-> !gauge_calibrate_discharge_o)
    else $error("calibrate kept with pin low");
endmodule
bind coc_charge_option coc_charge_option_chk u_chk (.clk_sys_i, .reset_i,
  .battery_present_pin_n_i, .otg_mode_i, .adapter_detect_i, .pass_through_mode_i,
  .settings_valid_i, .bat_mon_en_i, .internal_regulator_on_o, .battery_current_monitor_on_o,
  .adapter_good_out_o, .passthrough_ripple_reduce_o, .gauge_calibrate_discharge_o,
  .charge_run_o, .wdog_expired_o, .charge_current_zero_o, .ext_wr_o, .ext_addr_o);

// ==== coc_host.sv ====
// host bus master model for the two-wire serial bus
`timescale 1ns/1ps
module coc_host (
  input  wire logic clk_i,
  input  wire logic dev_pull_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic low = 1'b0;
  initial scl_o = 1'b1;
  // pull-up: released wire reads high
  assign sda_o = ~(low | dev_pull_i);
  task automatic hp();
    repeat (5) @(negedge clk_i);
  endtask
  task automatic start();
    low = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    low = 1'b1;
    hp();
    scl_o = 1'b0;
    hp();
  endtask
  task automatic stop();
    low = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    low = 1'b0;
    hp();
  endtask
  task automatic xbit(input logic b, output logic s);
    low = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    s = sda_o;
    scl_o = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(last, ack);
    ack = ~ack;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] q[$],
                    output logic ok);
    logic [7:0] x;
    logic       a;
    start();
    xbyte({dev, 1'b0}, 1'b1, x, ok);
    xbyte(ra, 1'b1, x, a);
    foreach (q[i]) xbyte(q[i], 1'b1, x, a);
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra, output logic [15:0] d);
    logic a;
    start();
    xbyte({dev, 1'b0}, 1'b1, d[7:0], a);
    xbyte(ra, 1'b1, d[7:0], a);
    start();
    xbyte({dev, 1'b1}, 1'b1, d[7:0], a);
    xbyte(8'hFF, 1'b0, d[7:0], a);
    xbyte(8'hFF, 1'b1, d[15:8], a);
    stop();
  endtask
endmodule

// ==== coc_pkg.sv ====
// constants and types shared by the charge option control block
package coc_pkg;

  // serial bus identity and register map
  localparam logic [6:0]  I2C_DEV_ADDR = 7'h6B;
  localparam logic [7:0]  REG_OPT_LO   = 8'h00;
  localparam logic [7:0]  REG_OPT_HI   = 8'h01;
  localparam logic [7:0]  REG_CUR_LO   = 8'h02;
  localparam logic [7:0]  REG_VOLT_HI  = 8'h05;
  localparam logic [15:0] CFG_RESET    = 16'hE70E;

  // field positions within the 16-bit register
  localparam int BIT_CHARGE_BLOCK   = 0;
  localparam int BIT_INPUT_LIMIT_ON = 1;
  localparam int BIT_LINEAR_PRECHG  = 2;
  localparam int BIT_BAT_GAIN       = 3;
  localparam int BIT_IN_GAIN        = 4;
  localparam int BIT_GAUGE_CAL      = 5;
  localparam int BIT_SHORT_RETRY    = 6;
  localparam int BIT_RIPPLE_REDUCE  = 8;
  localparam int BIT_RATE_SEL       = 9;
  localparam int BIT_AUDIO_AVOID    = 10;
  localparam int BIT_SRC_FLAGS_GOOD = 11;
  localparam int BIT_LIMIT_AUTO_OFF = 12;
  localparam int BIT_WD_SEL_LO      = 13;
  localparam int BIT_LOW_POWER      = 15;

  // watchdog period codes and periods
  localparam logic [1:0] WD_SEL_OFF  = 2'h0;
  localparam logic [1:0] WD_SEL_5S   = 2'h1;
  localparam logic [1:0] WD_SEL_77S  = 2'h2;
  localparam logic [1:0] WD_SEL_153S = 2'h3;
  localparam int WD_P1_S     = 5;
  localparam int WD_P2_S     = 77;
  localparam int WD_P3_S     = 153;
  localparam int MS_PER_S    = 1000;
  localparam int WD_CNT_W    = 18;

  // clock and watchdog tick
  localparam int CLK_MHZ        = 125;
  localparam int WD_TICK_US     = 1000;
  localparam int WD_TICK_CYCLES = WD_TICK_US * CLK_MHZ;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_RX   = 6'b000100,
    ST_ACK  = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } coc_bus_st_t;

endpackage

// ==== coc_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module coc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } coc_sync_st_t;

  coc_sync_st_t q;
  coc_sync_st_t n;

  if (W < 1) begin : g_chk
    $error("coc_sync width must be at least one");
  end

  always_comb begin
    n.s1 = d_i;
    n.s2 = q.s1;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '1;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.s2;
endmodule

// ==== coc_wdog.sv ====
// charge setting watchdog: millisecond divider and period counter
`timescale 1ns/1ps
module coc_wdog import coc_pkg::*; #(
  parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] period_sel_i,
  input  wire logic       kick_i,
  output logic            expire_o
);
  localparam int DW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [DW-1:0]       div;
    logic [WD_CNT_W-1:0] count;
    logic                fired;
    logic                expire;
  } coc_wdog_st_t;

  coc_wdog_st_t        q;
  coc_wdog_st_t        n;
  logic                tick;
  logic [WD_CNT_W-1:0] limit;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("coc_wdog tick must be at least one cycle");
  end

  assign tick = (q.div == DW'(TICK_CYCLES - 1));

  always_comb begin
    unique case (period_sel_i)
      WD_SEL_5S:   limit = WD_CNT_W'(WD_P1_S * MS_PER_S);
      WD_SEL_77S:  limit = WD_CNT_W'(WD_P2_S * MS_PER_S);
      WD_SEL_153S: limit = WD_CNT_W'(WD_P3_S * MS_PER_S);
      default:     limit = '0;
    endcase
  end

  always_comb begin
    n = q;
    n.expire = 1'b0;
    n.div = tick ? '0 : q.div + DW'(1);
    if (kick_i || period_sel_i == WD_SEL_OFF) begin
      n.div   = '0;
      n.count = '0;
      n.fired = 1'b0;
    end else if (tick && !q.fired) begin
      if (q.count == limit - WD_CNT_W'(1)) begin
        n.expire = 1'b1;
        n.fired  = 1'b1;
        n.count  = '0;
      end else begin
        n.count = q.count + WD_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign expire_o = q.expire;
endmodule

// ==== testbench.sv ====
// self-checking bench for the charge option block
`timescale 1ns/1ps
module testbench import coc_pkg::*;;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        bat_pin_n = 1'b1;
  logic [9:0]  rin       = 10'h000;
  logic        scl, sda, sda_oe, reg_on, bmon, smon, adcon, thr, cmp, agood, psf, rate, rip;
  logic        hic, gauge, ig, bg, lin, ilim, run, wexp, zero, ewr, ok, sdo;
  logic [7:0]  eaddr, edata;
  logic [15:0] v, rdv;
  logic [31:0] seed = 32'h00001070;
  int          mismatches = 0, num_checks = 0, zero_cnt = 0, ewr_cnt = 0, n;
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (zero === 1'b1) zero_cnt <= zero_cnt + 1;
  always @(posedge clk_sys_i) if (ewr === 1'b1) ewr_cnt <= ewr_cnt + 1;
  coc_host host (.clk_i(clk_sys_i), .dev_pull_i(sda_oe), .scl_o(scl), .sda_o(sda));
  coc_charge_option #(.TICK_CYCLES(2)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe), .battery_present_pin_n_i(bat_pin_n),
    .battery_only_i(rin[9]), .adapter_detect_i(rin[8]), .otg_mode_i(rin[7]),
    .pass_through_mode_i(rin[6]), .settings_valid_i(rin[5]), .bat_mon_en_i(rin[4]),
    .sys_pwr_mon_en_i(rin[3]), .adc_en_i(rin[2]), .throttle_en_i(rin[1]),
    .comparator_en_i(rin[0]), .internal_regulator_on_o(reg_on),
    .battery_current_monitor_on_o(bmon), .system_power_monitor_on_o(smon),
    .adc_sampling_on_o(adcon), .throttle_output_on_o(thr), .comparator_on_o(cmp),
    .adapter_good_out_o(agood), .pulse_skip_floor_o(psf), .switching_rate_800k_o(rate),
    .passthrough_ripple_reduce_o(rip), .hiccup_on_o(hic), .gauge_calibrate_discharge_o(gauge),
    .input_sense_gain_40x_o(ig), .battery_sense_gain_16x_o(bg), .linear_precharge_on_o(lin),
    .input_limit_regulation_o(ilim), .charge_run_o(run), .wdog_expired_o(wexp),
    .charge_current_zero_o(zero), .ext_wr_o(ewr), .ext_addr_o(eaddr), .ext_data_o(edata));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [7:0] cfg_outs(input logic [15:0] c);
    return {c[10], c[9], ~c[6], c[5], c[4], c[3], c[2], c[1]};
  endfunction
  function automatic logic [7:0] gate_outs(input logic [15:0] c, input logic [9:0] r);
    logic lp;
    lp = c[15] & r[9];
    return {~lp, r[4] & ~lp, r[3] & ~lp, r[2] & ~lp, r[1], r[0], r[8] | (c[11] & r[7]),
            c[8] & r[6]};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_exp(input int lim);
    n = 0;
    while (wexp !== 1'b1 && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    host.rd(I2C_DEV_ADDR, REG_OPT_LO, rdv);
    check("reset value", rdv, CFG_RESET);
    check("reset outputs", {psf, rate, hic, gauge, ig, bg, lin, ilim}, cfg_outs(CFG_RESET));
    check("open drain level", sdo, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd();
      rin = 10'(rnd());
      host.wr(I2C_DEV_ADDR, REG_OPT_LO, '{v[7:0], v[15:8]}, ok);
      check("address ack", ok, 1'b1);
      host.rd(I2C_DEV_ADDR, REG_OPT_LO, rdv);
      check("readback", rdv, v);
      check("option outputs", {psf, rate, hic, gauge, ig, bg, lin, ilim}, cfg_outs(v));
      check("skip floor", psf, v[BIT_AUDIO_AVOID]);
      check("rate select", rate, v[BIT_RATE_SEL]);
      check("hiccup", hic, !v[BIT_SHORT_RETRY]);
      check("battery gain", bg, v[BIT_BAT_GAIN]);
      check("linear precharge", lin, v[BIT_LINEAR_PRECHG]);
      check("gated outputs", {reg_on, bmon, smon, adcon, thr, cmp, agood, rip},
            gate_outs(v, rin));
      check("monitor follow", bmon, rin[4] && !(v[BIT_LOW_POWER] && rin[9]));
      check("adapter good", agood, rin[8] || (v[BIT_SRC_FLAGS_GOOD] && rin[7]));
      check("ripple reduce", rip, v[BIT_RIPPLE_REDUCE] && rin[6]);
      check("charge run", run, ~v[0] & rin[5]);
      $display("random config %0d done", i);
    end
    rin = 10'h020;
    host.wr(I2C_DEV_ADDR, REG_OPT_LO, '{8'h0E, 8'hA7}, ok);
    repeat (8000) @(negedge clk_sys_i);
    host.wr(I2C_DEV_ADDR, 8'h04, '{8'h5A}, ok);
    check("setting address", eaddr, 8'h04);
    check("setting data", edata, 8'h5A);
    check("no early expiry", wexp, 1'b0);
    check("setting strobes", ewr_cnt, 1);
    wait_exp(12000);
    if (n >= 12000) begin
      mismatches++;
      final_report();
    end
    @(negedge clk_sys_i);
    check("short period", n >= 9900 && n <= 10010, 1'b1);
    check("zero pulses", zero_cnt, 1);
    check("charging halted", run, 1'b0);
    host.wr(I2C_DEV_ADDR, 8'h03, '{8'h00}, ok);
    check("expiry cleared", wexp, 1'b0);
    check("charging resumed", run, 1'b1);
    check("second strobe", ewr_cnt, 2);
    host.wr(I2C_DEV_ADDR, REG_OPT_HI, '{8'h87}, ok);
    repeat (11000) @(negedge clk_sys_i);
    check("watchdog off", wexp, 1'b0);
    $display("watchdog test done");
    host.wr(I2C_DEV_ADDR, REG_OPT_LO, '{8'h22, 8'h97}, ok);
    check("limit set", {ilim, gauge}, 2'b11);
    bat_pin_n = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    check("limit auto off", ilim, 1'b0);
    check("calibrate cleared", gauge, 1'b0);
    host.wr(I2C_DEV_ADDR, REG_OPT_LO, '{8'h22}, ok);
    repeat (2) @(negedge clk_sys_i);
    check("limit rewritten", {ilim, gauge}, 2'b10);
    bat_pin_n = 1'b1;
    host.wr(7'h6A, REG_OPT_LO, '{8'h00}, ok);
    check("foreign address", ok, 1'b0);
    host.rd(I2C_DEV_ADDR, REG_OPT_LO, rdv);
    check("register kept", rdv, 16'h9702);
    host.rd(I2C_DEV_ADDR, 8'h40, rdv);
    check("unmapped read", rdv, 16'h0000);
    $display("pin and address test done");
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("second reset", {psf, rate, hic, gauge, ig, bg, lin, ilim}, cfg_outs(CFG_RESET));
    $display("second reset test done");
    final_report();
  end
endmodule
